// ---- logic/cms_pkg.sv ----
package cms_pkg;
	// global mode field encodings
	localparam logic [1:0] GMODE_OPER  = 2'h0;
	localparam logic [1:0] GMODE_RESET = 2'h1;
	localparam logic [1:0] GMODE_TEST  = 2'h2;
	// channel mode field encodings
	localparam logic [1:0] CMODE_COMM  = 2'h0;
	localparam logic [1:0] CMODE_RESET = 2'h1;
	localparam logic [1:0] CMODE_HALT  = 2'h2;
	// reset values
	localparam logic [1:0] GMODE_RST_VAL = GMODE_RESET;
	localparam logic       GSLEEP_RST_VAL = 1'b1;
	localparam logic [1:0] CMODE_RST_VAL = CMODE_RESET;
	localparam logic       CSLEEP_RST_VAL = 1'b1;
	// timing and config width
	localparam int         RECESSIVE_RUN   = 11;
	localparam int         RAM_INIT_CYCLES = 64;
	localparam int         BUS_LOCK_BITS   = 11;
	localparam int         BIT_DIV         = 50;
	localparam int         CFG_W           = 16;

	typedef enum logic [2:0] {
		CMS_ST_STOP,
		CMS_ST_RESET,
		CMS_ST_HALT,
		CMS_ST_COMM_WAIT,
		CMS_ST_COMM
	} cms_chan_t;

	typedef enum logic [1:0] {
		CMS_G_STOP,
		CMS_G_RESET,
		CMS_G_TEST,
		CMS_G_OPER
	} cms_glob_t;

	function automatic logic [1:0] cms_gcode(input cms_glob_t g);
		case (g)
			CMS_G_RESET: cms_gcode = GMODE_RESET;
			CMS_G_TEST:  cms_gcode = GMODE_TEST;
			default:     cms_gcode = GMODE_OPER;
		endcase
	endfunction
endpackage

// ---- logic/cms_if.sv ----
`timescale 1ns/100ps
interface cms_if;
	logic              periph_en;
	logic              ext_clk_en;
	logic              g_sleep;
	logic [1:0]        g_mode;
	logic              c_sleep;
	logic [1:0]        c_mode;
	logic              cfg_we;
	logic [15:0]       cfg_wdata;
	logic              test_we;
	logic [15:0]       test_wdata;
	logic              ram_rd;
	logic              ram_init_status;
	logic              g_stop_sts;
	logic [1:0]        g_mode_sts;
	logic              c_stop_sts;
	logic [1:0]        c_mode_sts;
	logic              comm_ready_flag;
	logic              bus_lock_flag;
	logic [15:0]       cfg_rdata;
	logic [15:0]       test_rdata;
	logic [7:0]        ram_rdata;

	modport dev (
		input  periph_en, ext_clk_en, g_sleep, g_mode, c_sleep, c_mode,
		input  cfg_we, cfg_wdata, test_we, test_wdata, ram_rd,
		output ram_init_status, g_stop_sts, g_mode_sts, c_stop_sts, c_mode_sts,
		output comm_ready_flag, bus_lock_flag, cfg_rdata, test_rdata, ram_rdata
	);
	modport host (
		output periph_en, ext_clk_en, g_sleep, g_mode, c_sleep, c_mode,
		output cfg_we, cfg_wdata, test_we, test_wdata, ram_rd,
		input  ram_init_status, g_stop_sts, g_mode_sts, c_stop_sts, c_mode_sts,
		input  comm_ready_flag, bus_lock_flag, cfg_rdata, test_rdata, ram_rdata
	);
endinterface

// ---- logic/cms_device.sv ----
`timescale 1ns/100ps
// Contract
// [RQ1] software configures before any communication start
// [RQ2] configuration writes only in reset or halt
// [RQ3] software enables peripheral, then initialises module
// [RQ4] no RAM access before RAM init done
// [RQ5] external clock needs supply enable set
// [RQ6] global mode request, status reports completion
// [RQ7] channel mode request, status reports completion
// [RQ8] comm ready after 11 recessive bits
// [RQ9] channel mode follows global transition
// [RQ10] channel reset completes immediately, aborting frame
// [RQ11] halt first for graceful reset
// [RQ12] settings kept across channel reset
// [RQ13] settings kept across channel halt
// [RQ14] software configures in order, then comm
// [RQ15] bus lock refuses halt request
// [RQ16] global stop: reads kept, writes ignored
// [RQ17] halt stops bus, test settings writable
// [RQ18] global test stops all channels
// [RQ19] status shows old mode until reached
module cms_device
	import cms_pkg::*;
#(
	parameter int RAM_INIT = RAM_INIT_CYCLES,
	parameter int DIV      = BIT_DIV
) (
	input  wire logic mclk_i,
	input  wire logic resetn_i,
	input  wire logic can_rx_i,
	output logic      can_tx_o,
	output logic      bus_active_o,
	cms_if.dev        bus
);
	cms_glob_t   glob_ff;
	cms_chan_t   chan_ff;
	logic [7:0]  ram_cnt_ff;
	logic        ram_done_ff;
	logic [7:0]  bit_cnt_ff;
	logic        bit_tick;
	logic [3:0]  rec_cnt_ff;
	logic [3:0]  dom_cnt_ff;
	logic        lock_ff;
	logic [15:0] cfg_ff;
	logic [15:0] test_ff;
	logic        clk_run;
	logic        cfg_open;

	// reset and stop both leave the channel parked off the bus
	function automatic logic chan_parked(input cms_chan_t c);
		chan_parked = c == CMS_ST_RESET || c == CMS_ST_STOP;
	endfunction

	// module clock gated when disabled or in global stop
	assign clk_run = bus.periph_en && glob_ff != CMS_G_STOP; // see [RQ16]

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ram_cnt_ff  <= 8'h00;
			ram_done_ff <= 1'b0;
		end else if (!bus.periph_en) begin
			ram_cnt_ff  <= 8'h00;
			ram_done_ff <= 1'b0;
		end else if (!ram_done_ff) begin
			if (ram_cnt_ff == 8'(RAM_INIT - 1)) begin
				ram_done_ff <= 1'b1;
			end
			ram_cnt_ff <= ram_cnt_ff + 8'h01;
		end
	end
	// ram reads before init give zero; software must wait anyway
	assign bus.ram_init_status = ram_done_ff; // see [RQ4]
	assign bus.ram_rdata       = (ram_done_ff && bus.ram_rd) ? cfg_ff[7:0] : 8'h00;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_cnt_ff <= 8'h00;
		end else if (bit_tick || !clk_run) begin
			bit_cnt_ff <= 8'h00;
		end else begin
			bit_cnt_ff <= bit_cnt_ff + 8'h01;
		end
	end
	// divider restarts whenever the module clock is gated
	assign bit_tick = clk_run && bit_cnt_ff == 8'(DIV - 1);

	// global mode: requests take effect only while ram init done
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			glob_ff <= CMS_G_STOP;
		end else if (bus.periph_en && ram_done_ff) begin
			if (bus.g_sleep) begin
				if (glob_ff == CMS_G_RESET) begin
					glob_ff <= CMS_G_STOP; // see [RQ6]
				end
			end else if (bus.g_mode == GMODE_RESET) begin
				glob_ff <= CMS_G_RESET;
			end else if (glob_ff != CMS_G_STOP) begin
				if (bus.g_mode == GMODE_TEST) begin
					glob_ff <= CMS_G_TEST;
				end else if (bus.g_mode == GMODE_OPER) begin
					glob_ff <= CMS_G_OPER;
				end
			end
		end
	end

	// channel mode; global state bounds the channel state
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			chan_ff <= CMS_ST_STOP;
		end else if (glob_ff == CMS_G_STOP) begin
			chan_ff <= CMS_ST_STOP; // see [RQ9]
		end else if (glob_ff == CMS_G_RESET) begin
			if (chan_ff != CMS_ST_STOP || !bus.c_sleep) begin
				chan_ff <= CMS_ST_RESET; // see [RQ9]
			end
		end else if (bus.c_sleep) begin
			if (chan_ff == CMS_ST_RESET) begin
				chan_ff <= CMS_ST_STOP;
			end
		end else if (bus.c_mode == CMODE_RESET) begin
			chan_ff <= CMS_ST_RESET; // see [RQ10]
		end else if (glob_ff == CMS_G_TEST && chan_ff != CMS_ST_STOP
				&& chan_ff != CMS_ST_RESET) begin
			chan_ff <= CMS_ST_HALT; // see [RQ18]
		end else if (chan_ff == CMS_ST_STOP) begin
			chan_ff <= chan_ff;
		end else if (bus.c_mode == CMODE_HALT) begin
			if (!lock_ff || chan_ff == CMS_ST_HALT) begin
				chan_ff <= CMS_ST_HALT; // see [RQ15]
			end
		end else if (bus.c_mode == CMODE_COMM && glob_ff == CMS_G_OPER) begin
			if (chan_ff == CMS_ST_RESET || chan_ff == CMS_ST_HALT) begin
				chan_ff <= CMS_ST_COMM_WAIT;
			end else if (chan_ff == CMS_ST_COMM_WAIT && bit_tick
					&& can_rx_i && rec_cnt_ff == 4'(RECESSIVE_RUN - 1)) begin
				chan_ff <= CMS_ST_COMM; // see [RQ8]
			end
		end
	end

	// recessive run counter and bus-lock detector, counted per bit time
	// one dominant bit restarts the run, so a busy bus delays joining
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rec_cnt_ff <= 4'h0;
		end else if (chan_ff != CMS_ST_COMM_WAIT) begin
			rec_cnt_ff <= 4'h0;
		end else if (bit_tick) begin
			rec_cnt_ff <= can_rx_i ? rec_cnt_ff + 4'h1 : 4'h0; // see [RQ8]
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dom_cnt_ff <= 4'h0;
			lock_ff    <= 1'b0;
		end else if (chan_parked(chan_ff)) begin
			dom_cnt_ff <= 4'h0;
			lock_ff    <= 1'b0;
		end else if (bit_tick) begin
			if (can_rx_i) begin
				dom_cnt_ff <= 4'h0;
				lock_ff    <= 1'b0;
			end else if (dom_cnt_ff == 4'(BUS_LOCK_BITS - 1)) begin
				lock_ff <= 1'b1; // see [RQ15]
			end else begin
				dom_cnt_ff <= dom_cnt_ff + 4'h1;
			end
		end
	end

	// configuration storage is never cleared by mode changes
	assign cfg_open = clk_run && (glob_ff == CMS_G_RESET || chan_ff == CMS_ST_RESET
		|| chan_ff == CMS_ST_HALT); // see [RQ2]
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_ff <= 16'h0000;
		end else if (bus.cfg_we && cfg_open) begin
			cfg_ff <= bus.cfg_wdata; // see [RQ12] see [RQ13]
		end
	end
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			test_ff <= 16'h0000;
		end else if (bus.test_we && clk_run && (chan_ff == CMS_ST_HALT
				|| glob_ff == CMS_G_TEST || glob_ff == CMS_G_RESET)) begin
			test_ff <= bus.test_wdata; // see [RQ17]
		end
	end
	assign bus.cfg_rdata  = cfg_ff;
	assign bus.test_rdata = test_ff;

	// status taken straight from the state registers
	assign bus.g_stop_sts      = glob_ff == CMS_G_STOP; // see [RQ19]
	assign bus.g_mode_sts      = cms_gcode(glob_ff);
	assign bus.c_stop_sts      = chan_ff == CMS_ST_STOP;
	assign bus.c_mode_sts      = chan_ff == CMS_ST_HALT ? CMODE_HALT :
		chan_parked(chan_ff) ? CMODE_RESET : CMODE_COMM; // see [RQ7]
	assign bus.comm_ready_flag = chan_ff == CMS_ST_COMM;
	assign bus.bus_lock_flag   = lock_ff;

	// only a joined channel may drive; transmitter stays recessive here
	assign bus_active_o = chan_ff == CMS_ST_COMM; // see [RQ17]
	assign can_tx_o     = 1'b1;
endmodule

// ---- logic/cms_host.sv ----
`timescale 1ns/100ps
module cms_host
	import cms_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	input  wire logic        start_i,
	input  wire logic        use_ext_clk_i,
	input  wire logic [15:0] cfg_i,
	output logic             busy_o,
	output logic             done_o,
	cms_if.host              bus
);
	typedef enum logic [2:0] {
		H_IDLE, H_RAMWAIT, H_GRESET, H_CRESET, H_CFG, H_GOPER, H_COMM, H_DONE
	} cms_host_t;
	cms_host_t   st_ff;
	logic [1:0]  gmode_ff;
	logic        gsleep_ff;
	logic [1:0]  cmode_ff;
	logic        csleep_ff;
	logic        pen_ff;
	logic        ext_ff;
	logic        we_ff;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_ff     <= H_IDLE;
			pen_ff    <= 1'b0;
			ext_ff    <= 1'b0;
			gsleep_ff <= GSLEEP_RST_VAL;
			gmode_ff  <= GMODE_RST_VAL;
			csleep_ff <= CSLEEP_RST_VAL;
			cmode_ff  <= CMODE_RST_VAL;
			we_ff     <= 1'b0;
		end else begin
			we_ff <= 1'b0;
			case (st_ff)
				H_IDLE: begin
					if (start_i) begin
						pen_ff <= 1'b1; // see [RQ3]
						ext_ff <= use_ext_clk_i; // see [RQ5]
						st_ff  <= H_RAMWAIT;
					end
				end
				H_RAMWAIT: begin
					if (bus.ram_init_status) begin // see [RQ4]
						gsleep_ff <= 1'b0;
						gmode_ff  <= GMODE_RESET;
						st_ff     <= H_GRESET;
					end
				end
				H_GRESET: begin
					if (!bus.g_stop_sts && bus.g_mode_sts == GMODE_RESET) begin // see [RQ6]
						csleep_ff <= 1'b0;
						cmode_ff  <= CMODE_RESET;
						st_ff     <= H_CRESET;
					end
				end
				H_CRESET: begin
					if (!bus.c_stop_sts && bus.c_mode_sts == CMODE_RESET) begin
						we_ff <= 1'b1; // see [RQ1] see [RQ14]
						st_ff <= H_CFG;
					end
				end
				H_CFG: begin
					gmode_ff <= GMODE_OPER;
					st_ff    <= H_GOPER;
				end
				H_GOPER: begin
					if (bus.g_mode_sts == GMODE_OPER) begin
						cmode_ff <= CMODE_COMM;
						st_ff    <= H_COMM;
					end
				end
				H_COMM: begin
					if (bus.comm_ready_flag) begin
						st_ff <= H_DONE;
					end
				end
				default: begin
					st_ff <= st_ff;
				end
			endcase
		end
	end

	assign bus.periph_en  = pen_ff;
	assign bus.ext_clk_en = ext_ff;
	assign bus.g_sleep    = gsleep_ff;
	assign bus.g_mode     = gmode_ff;
	assign bus.c_sleep    = csleep_ff;
	assign bus.c_mode     = cmode_ff;
	assign bus.cfg_we     = we_ff;
	assign bus.cfg_wdata  = cfg_i;
	assign bus.test_we    = 1'b0;
	assign bus.test_wdata = 16'h0000;
	// message ram is read only once joined, long after init is done
	assign bus.ram_rd     = st_ff == H_DONE; // see [RQ4]
	assign busy_o         = st_ff != H_IDLE && st_ff != H_DONE;
	assign done_o         = st_ff == H_DONE;
endmodule

// ---- verification/cms_monitor.sv ----
`timescale 1ns/100ps
module cms_monitor
	import cms_pkg::*;
(
	input wire logic        mclk_i,
	input wire logic        resetn_i,
	input wire logic        ram_rd,
	input wire logic        ram_init_status,
	input wire logic        g_sleep,
	input wire logic [1:0]  g_mode,
	input wire logic        g_stop_sts,
	input wire logic [1:0]  g_mode_sts,
	input wire logic        c_sleep,
	input wire logic [1:0]  c_mode,
	input wire logic        c_stop_sts,
	input wire logic [1:0]  c_mode_sts,
	input wire logic        comm_ready_flag,
	input wire logic        bus_lock_flag,
	input wire logic        cfg_we,
	input wire logic [15:0] cfg_rdata
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	ram_gate_a: assert property (ram_rd |-> ram_init_status)
		else $error("ram read before init");
	init_hold_a: assert property (
		!ram_init_status |=> $stable(g_mode_sts) && $stable(g_stop_sts))
		else $error("mode moved before init");
	glob_answer_a: assert property (
		!g_sleep && !g_stop_sts && ram_init_status && g_mode != g_mode_sts
		|=> g_mode_sts == $past(g_mode)) else $error("global status late");
	glob_hold_a: assert property (
		!g_sleep && g_mode == g_mode_sts |=> $stable(g_mode_sts))
		else $error("global status moved");
	cfg_gate_a: assert property (
		cfg_we && (g_stop_sts || (!c_stop_sts && c_mode_sts == CMODE_COMM
		&& g_mode_sts == GMODE_OPER)) |=> $stable(cfg_rdata)) else $error("cfg write taken");
	ready_wait_a: assert property (
		$rose(comm_ready_flag) |-> c_mode_sts == CMODE_COMM
		&& $past(c_mode_sts, 20) == CMODE_COMM) else $error("ready too early");
	halt_lock_a: assert property (
		bus_lock_flag && c_mode == CMODE_HALT && c_mode_sts != CMODE_HALT
		|=> c_mode_sts != CMODE_HALT) else $error("halt under bus lock");
	chan_reset_a: assert property (
		!c_sleep && c_mode == CMODE_RESET && !c_stop_sts && !g_stop_sts && ram_init_status
		|=> c_mode_sts == CMODE_RESET) else $error("reset not immediate");
	glob_follow_a: assert property (
		g_mode_sts == GMODE_RESET && !g_stop_sts
		|=> c_stop_sts || c_mode_sts == CMODE_RESET) else $error("channel not reset");
	test_quiet_a: assert property (
		g_mode_sts == GMODE_TEST && !g_stop_sts |=> !comm_ready_flag)
		else $error("comm in test mode");
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/100ps
module tb;
	import cms_pkg::*;
	typedef struct packed {
		logic [1:0] gm;
		logic [1:0] cm;
		logic [1:0] e_gm;
		logic [1:0] e_cm;
		logic       we_ok;
	} cms_row_t;
	logic        mclk_i;
	logic        resetn_i;
	logic        start_i;
	logic        use_ext_clk_i;
	logic        rx_a;
	logic        rx_b;
	logic [15:0] cfg_i;
	logic [15:0] last_cfg;
	wire logic   busy_o;
	wire logic   done_o;
	wire logic   can_tx_o;
	wire logic   bus_active_o;
	int          bad_count;
	int          comparisons;
	int          n;
	cms_row_t    rows [7] = '{
		'{GMODE_RESET, CMODE_RESET, GMODE_RESET, CMODE_RESET, 1'b1},
		'{GMODE_OPER,  CMODE_RESET, GMODE_OPER,  CMODE_RESET, 1'b1},
		'{GMODE_OPER,  CMODE_HALT,  GMODE_OPER,  CMODE_HALT,  1'b1},
		'{GMODE_OPER,  CMODE_COMM,  GMODE_OPER,  CMODE_COMM,  1'b0},
		'{GMODE_TEST,  CMODE_COMM,  GMODE_TEST,  CMODE_HALT,  1'b1},
		'{GMODE_RESET, CMODE_COMM,  GMODE_RESET, CMODE_RESET, 1'b1},
		'{GMODE_OPER,  CMODE_RESET, GMODE_OPER,  CMODE_RESET, 1'b1}};
	cms_if ifc();
	cms_if ifb();
	cms_device #(.RAM_INIT(4), .DIV(2)) u_cms_device (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.can_rx_i(rx_a), .can_tx_o(can_tx_o), .bus_active_o(bus_active_o), .bus(ifc));
	cms_host u_cms_host (.mclk_i(mclk_i), .resetn_i(resetn_i), .start_i(start_i),
		.use_ext_clk_i(use_ext_clk_i), .cfg_i(cfg_i), .busy_o(busy_o), .done_o(done_o), .bus(ifc));
	// second device driven straight by the bench, so refusals can be provoked
	cms_device #(.RAM_INIT(4), .DIV(2)) u_cms_device_b (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.can_rx_i(rx_b), .can_tx_o(), .bus_active_o(), .bus(ifb));
	cms_monitor u_cms_monitor (.mclk_i(mclk_i), .resetn_i(resetn_i), .ram_rd(ifc.ram_rd),
		.ram_init_status(ifc.ram_init_status), .g_sleep(ifc.g_sleep), .g_mode(ifc.g_mode),
		.g_stop_sts(ifc.g_stop_sts), .g_mode_sts(ifc.g_mode_sts), .c_sleep(ifc.c_sleep),
		.c_mode(ifc.c_mode), .c_stop_sts(ifc.c_stop_sts), .c_mode_sts(ifc.c_mode_sts),
		.comm_ready_flag(ifc.comm_ready_flag), .bus_lock_flag(ifc.bus_lock_flag),
		.cfg_we(ifc.cfg_we), .cfg_rdata(ifc.cfg_rdata));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	task automatic cfg_wr(input logic [15:0] v);
		ifb.cfg_wdata = v;
		ifb.cfg_we = 1'b1;
		cyc(1);
		ifb.cfg_we = 1'b0;
	endtask
	task automatic test_wr(input logic [15:0] v);
		ifb.test_wdata = v;
		ifb.test_we = 1'b1;
		cyc(1);
		ifb.test_we = 1'b0;
	endtask
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	// whole run is a few hundred cycles; this leaves wide margin
	initial begin
		#400000;
		bad_count++;
		complete_run();
	end
	initial begin
		{resetn_i, start_i, rx_a, ifb.periph_en, ifb.ext_clk_en, ifb.c_sleep} = '0;
		{use_ext_clk_i, rx_b, ifb.g_sleep} = '1;
		{ifb.cfg_we, ifb.test_we, ifb.ram_rd, ifb.cfg_wdata, ifb.test_wdata} = '0;
		cfg_i = 16'hA5C3;
		ifb.g_mode = GMODE_RESET;
		ifb.c_mode = CMODE_RESET;
		cyc(20);
		resetn_i = 1'b1;
		start_i = 1'b1;
		cyc(60);
		check(16'(done_o), 16'h0);
		check(16'(busy_o), 16'h1);
		check(16'(ifc.bus_lock_flag), 16'h1);
		check(16'(ifc.ext_clk_en), 16'h1);
		rx_a = 1'b1;
		n = 0;
		while (done_o !== 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
		check(16'(n >= 20), 16'h1);
		check(16'(ifc.comm_ready_flag), 16'h1);
		check(16'(bus_active_o & can_tx_o), 16'h1);
		check(16'(busy_o), 16'h0);
		check(ifc.cfg_rdata, 16'hA5C3);
		check(16'(ifc.g_mode_sts), 16'(GMODE_OPER));
		check(16'(ifc.c_mode_sts), 16'(CMODE_COMM));
		$display("walk test done");
		ifb.periph_en = 1'b1;
		cyc(3);
		check(16'(ifb.ram_init_status), 16'h0);
		cyc(2);
		check(16'(ifb.ram_init_status), 16'h1);
		{ifb.g_sleep, ifb.c_sleep} = '0;
		foreach (rows[i]) begin
			ifb.g_mode = rows[i].gm;
			ifb.c_mode = rows[i].cm;
			cyc(3);
			check(16'(ifb.g_mode_sts), 16'(rows[i].e_gm));
			check(16'(ifb.c_mode_sts), 16'(rows[i].e_cm));
			cfg_wr(16'(16'h1111 * (i + 1)));
			if (rows[i].we_ok)
				last_cfg = 16'(16'h1111 * (i + 1));
			check(ifb.cfg_rdata, last_cfg);
		end
		$display("mode table done");
		ifb.c_mode = CMODE_HALT;
		cyc(3);
		check(16'(ifb.c_mode_sts), 16'(CMODE_HALT));
		test_wr(16'h1234);
		check(ifb.test_rdata, 16'h1234);
		ifb.c_mode = CMODE_RESET;
		cyc(3);
		check(16'(ifb.c_mode_sts), 16'(CMODE_RESET));
		ifb.c_mode = CMODE_COMM;
		cyc(3);
		test_wr(16'h4321);
		check(ifb.test_rdata, 16'h1234);
		$display("halt test done");
		rx_b = 1'b0;
		cyc(40);
		check(16'(ifb.bus_lock_flag), 16'h1);
		ifb.c_mode = CMODE_HALT;
		cyc(4);
		check(16'(ifb.c_mode_sts), 16'(CMODE_COMM));
		ifb.c_mode = CMODE_RESET;
		cyc(1);
		check(16'(ifb.c_mode_sts), 16'(CMODE_RESET));
		check(ifb.cfg_rdata, last_cfg);
		$display("bus lock test done");
		ifb.g_mode = GMODE_RESET;
		cyc(3);
		cfg_wr(16'h5A5A);
		ifb.g_sleep = 1'b1;
		cyc(3);
		check(16'(ifb.g_stop_sts), 16'h1);
		cfg_wr(16'hBEEF);
		check(ifb.cfg_rdata, 16'h5A5A);
		$display("stop test done");
		resetn_i = 1'b0;
		cyc(2);
		check(16'({ifc.g_stop_sts, ifc.c_stop_sts, ifc.comm_ready_flag}), 16'h6);
		check(16'(ifc.periph_en), 16'h0);
		resetn_i = 1'b1;
		cyc(2);
		check(16'({ifc.periph_en, ifc.ram_init_status, ifc.g_stop_sts}), 16'h5);
		$display("reset test done");
		complete_run();
	end
endmodule
